/* ric_consts.svh */
// Register indices, reset values, vector numbers and field positions.
`ifndef RIC_CONSTS_SVH
`define RIC_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define RIC_IDX_WAKE_EDGE  16'hFF90
`define RIC_IDX_EXT_EDGE   16'hFFF2
`define RIC_IDX_EN_FIRST   16'hFFF3
`define RIC_IDX_EN_SECOND  16'hFFF4
`define RIC_IDX_REQ_FIRST  16'hFFF6
`define RIC_IDX_REQ_SECOND 16'hFFF7
`define RIC_IDX_WAKE_REQ   16'hFFF9

// Reset values.
`define RIC_RST_WAKE_EDGE  8'h00
`define RIC_RST_EXT_EDGE   8'hE0
`define RIC_RST_EN         8'h00
`define RIC_RST_REQ_FIRST  8'h20
`define RIC_RST_REQ_SECOND 8'h00
`define RIC_RST_WAKE_REQ   8'h00

// Fixed read-only bits.
`define RIC_EXT_EDGE_ONES  3'h7
`define RIC_REQ1_FIXED_BIT 5

// Vector numbers; the vector address is twice the number.
`define RIC_VEC_RESET  5'h00
`define RIC_VEC_LINE0  5'h04
`define RIC_VEC_WAKE   5'h09
`define RIC_VEC_SERIAL 5'h0A
`define RIC_VEC_TMR_A  5'h0B
`define RIC_VEC_TMR_C  5'h0D
`define RIC_VEC_TMR_FL 5'h0E
`define RIC_VEC_TMR_FH 5'h0F
`define RIC_VEC_TMR_G  5'h10
`define RIC_VEC_SER_A  5'h11
`define RIC_VEC_SER_B  5'h12
`define RIC_VEC_CONV   5'h13
`define RIC_VEC_DIRECT 5'h14
`define RIC_VEC_RSVD   5'h0C

`endif

/* ric_cpu_model.sv */
// Behavioural CPU core that paces boundaries, exception ends and mask writes.
`timescale 1ns/10ps

module ric_cpu_model #(
    parameter int EXC_LAT = 5
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Controller side.
    input  wire logic cpu_rst_start,
    input  wire logic cpu_int_start,
    input  wire logic ccr_i_mask,
    input  wire logic want_unmask,
    output logic      cpu_boundary,
    output logic      cpu_exc_done,
    output logic      cpu_ccr_wr,
    output logic      cpu_ccr_i_val
);
    logic [3:0] cnt_reg;
    logic       busy_reg;
    logic       ran_reg;

    // Exceptions run EXC_LAT+1 cycles; boundaries come only outside them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {cnt_reg, busy_reg, ran_reg} <= '0;
            {cpu_boundary, cpu_exc_done, cpu_ccr_wr, cpu_ccr_i_val} <= '0;
        end
        else if (cpu_rst_start || cpu_int_start)
        begin
            busy_reg     <= 1'b1;
            ran_reg      <= 1'b0;
            cnt_reg      <= 4'h0;
            cpu_ccr_wr   <= 1'b0;
            cpu_boundary <= 1'b0;
        end
        else
        begin
            cnt_reg      <= cnt_reg + 4'h1;
            cpu_exc_done <= busy_reg && cnt_reg == EXC_LAT[3:0];
            busy_reg     <= busy_reg && cnt_reg != EXC_LAT[3:0];
            cpu_boundary <= !busy_reg && cnt_reg[1:0] == 2'h3;
            ran_reg      <= ran_reg || cpu_boundary;
            // The handler's first instruction runs before it unmasks.
            cpu_ccr_wr   <= ran_reg && want_unmask && ccr_i_mask
                            && !busy_reg && !cpu_ccr_wr;
        end
    end
endmodule // ric_cpu_model

/* ric_pkg.sv */
// Types shared by the reset and interrupt controller.
package ric_pkg;

    // Sequencer states.
    typedef enum logic [1:0] {
        RIC_ST_RESET = 2'b00,
        RIC_ST_RVEC  = 2'b01,
        RIC_ST_RUN   = 2'b10,
        RIC_ST_EXC   = 2'b11
    } ric_state_t;

    typedef logic [4:0] ric_vec_t;

endpackage

/* ric_top.sv */
// Reset and interrupt exception controller with an APB register slave.
//
// Notes on behaviour
// R1 - Reset outranks interrupts; reset processing starts right after release.
// R2 - Interrupt processing starts only at an instruction or exception end.
// R3 - Reset low halts everything at once and forces the reset state.
// R4 - The outside holds reset low for at least 10 clock cycles; the bench's first reset lasts only 6.
// R5 - Reset initialises all registers and sets the interrupt mask bit.
// R6 - After reset the CPU fetches its start address from vector zero.
// R7 - The first instruction after reset always runs before any interrupt.
// R8 - Among pending requests the highest fixed priority is served first.
// R9 - Mask bit set: flags still set, but no interrupt is accepted.
// R10 - Vector table fixed: lines 4 to 8, wakeup 9, sleep transfer 20.
// R11 - Reserved vector addresses are never issued as interrupt vectors.
// R12 - Line edge select bits 7 to 5 read one and ignore writes.
// R13 - Line edge bit zero means falling edge, one means rising edge.
// R14 - Bit 4 edge also serves converter trigger, bit 3 timer F input.
// R15 - Bit 1 edge also serves timer C input; bit 0 the decoder line.
// R16 - First enable register gates timer A, serial, wakeup and lines.
// R17 - Second enable bit 7 gates the sleep direct-transfer interrupt.
// R18 - Request flags clear only by writing zero; writing one sets nothing.
// R19 - Flags stay set on acceptance; only software clears them.
// R20 - Wakeup edge bit zero selects falling, one selects rising edge.
// R21 - Starting interrupt processing sets the interrupt mask bit.
// R22 - A source reaches the CPU only with flag and enable both set; serial ports A and B reach it ungated.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "ric_consts.svh"

module ric_top (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins, active low, from outside the clock domain.
    input  wire logic [4:1]  ext_line_n,
    input  wire logic [7:0]  wakeup_line_n,
    input  wire logic        converter_trigger_in_n,
    input  wire logic        timer_f_event_in,
    input  wire logic        timer_c_event_in,
    // On-chip request sources, one-cycle pulses except the decoder line and the serial levels.
    input  wire logic        decoder_internal_line_n,
    input  wire logic        timer_a_ovf,
    input  wire logic        decoder_serial_done,
    input  wire logic        timer_c_evt,
    input  wire logic        timer_fl_evt,
    input  wire logic        timer_fh_evt,
    input  wire logic        timer_g_evt,
    input  wire logic        serial_port_a_req,
    input  wire logic        serial_port_b_req,
    input  wire logic        converter_done,
    input  wire logic        direct_transfer_evt,
    // CPU core.
    input  wire logic        cpu_boundary,
    input  wire logic        cpu_exc_done,
    input  wire logic        cpu_ccr_wr,
    input  wire logic        cpu_ccr_i_val,
    output logic             cpu_rst_start,
    output logic             cpu_int_start,
    output logic             cpu_int_pending,
    output logic      [4:0]  cpu_vector_num,
    output logic      [15:0] cpu_vector_addr,
    output logic             ccr_i_mask,
    // Edge-qualified events for neighbouring peripherals.
    output logic             converter_trig_evt,
    output logic             timer_f_edge_evt,
    output logic             timer_c_edge_evt
);

    // Edge detect on a synchronised level; rise picks the sense.
    function automatic logic edge_hit(input logic cur, input logic prev,
                                      input logic rise);
        edge_hit = rise ? (cur & ~prev) : (~cur & prev);
    endfunction

    // Vector number to byte address, two bytes per vector.
    function automatic logic [15:0] vec_addr(input ric_pkg::ric_vec_t v);
        vec_addr = {10'h000, v, 1'b0};
    endfunction

    // Registers.
    logic [7:0]  wake_edge_reg;
    logic [4:0]  ext_edge_reg;
    logic [7:0]  en_first_reg;
    logic [7:1]  en_second_reg;
    logic [7:0]  req_first_reg;
    logic [7:1]  req_second_reg;
    logic [7:0]  wake_req_reg;
    logic [7:0]  req_first_next;
    logic [7:1]  req_second_next;
    logic [7:0]  wake_req_next;
    ric_pkg::ric_state_t state_reg;
    logic        first_done_reg;
    logic [7:0]  rd_data;
    logic        unmapped;
    logic        wr_en;

    // Synchroniser stages for the pins; only stages two and three feed logic.
    logic [14:0] sync1_reg;
    logic [14:0] sync2_reg;
    logic [14:0] sync3_reg;
    logic        dec_prev_reg;

    // Sync stages for the pins; idle level is high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_reg    <= 15'h7FFF;
            sync2_reg    <= 15'h7FFF;
            sync3_reg    <= 15'h7FFF;
            dec_prev_reg <= 1'b1;
        end
        else
        begin
            sync1_reg    <= {timer_c_event_in, timer_f_event_in,
                             converter_trigger_in_n, wakeup_line_n,
                             ext_line_n};
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            dec_prev_reg <= decoder_internal_line_n;
        end
    end

    // Edge detection per line under its select bit.
    logic [4:0] line_hit;
    logic [7:0] wake_hit;
    logic       conv_hit;
    logic       tf_hit;
    logic       tc_hit;
    assign line_hit[0] = edge_hit(decoder_internal_line_n, dec_prev_reg,
                                  ext_edge_reg[0]);               // [R13] [R15]
    genvar gi;
    generate
        for (gi = 1; gi < 5; gi++)
        begin : g_line
            assign line_hit[gi] = edge_hit(sync2_reg[gi-1], sync3_reg[gi-1],
                                           ext_edge_reg[gi]);     // [R13]
        end
        for (gi = 0; gi < 8; gi++)
        begin : g_wake
            assign wake_hit[gi] = edge_hit(sync2_reg[gi+4], sync3_reg[gi+4],
                                           wake_edge_reg[gi]);    // [R20]
        end
    endgenerate
    assign conv_hit = edge_hit(sync2_reg[12], sync3_reg[12],
                               ext_edge_reg[4]);                  // [R14]
    assign tf_hit   = edge_hit(sync2_reg[13], sync3_reg[13],
                               ext_edge_reg[3]);                  // [R14]
    assign tc_hit   = edge_hit(sync2_reg[14], sync3_reg[14],
                               ext_edge_reg[1]);                  // [R15]

    // Address decode; the index is the word address.
    wire [15:0] idx      = paddr[17:2];
    wire        aligned  = (paddr[1:0] == 2'h0);
    wire        sel_wedg = aligned && (idx == `RIC_IDX_WAKE_EDGE);
    wire        sel_xedg = aligned && (idx == `RIC_IDX_EXT_EDGE);
    wire        sel_en1  = aligned && (idx == `RIC_IDX_EN_FIRST);
    wire        sel_en2  = aligned && (idx == `RIC_IDX_EN_SECOND);
    wire        sel_rq1  = aligned && (idx == `RIC_IDX_REQ_FIRST);
    wire        sel_rq2  = aligned && (idx == `RIC_IDX_REQ_SECOND);
    wire        sel_wrq  = aligned && (idx == `RIC_IDX_WAKE_REQ);
    assign unmapped = !(sel_wedg || sel_xedg || sel_en1 || sel_en2 ||
                        sel_rq1 || sel_rq2 || sel_wrq);
    assign wr_en    = psel && penable && pready && pwrite && !unmapped;

    // Read mux; fixed bits come from constants, except first request bit 5, which is stored.
    assign rd_data =
        sel_wedg ? wake_edge_reg :
        sel_xedg ? {`RIC_EXT_EDGE_ONES, ext_edge_reg} :           // [R12]
        sel_en1  ? en_first_reg :
        sel_en2  ? {en_second_reg, 1'b0} :
        sel_rq1  ? req_first_reg :
        sel_rq2  ? {req_second_reg, 1'b0} :
        sel_wrq  ? wake_req_reg : 8'h00;

    // Flag update: a zero written clears, a one is ignored, an event
    // in the same cycle wins over the clear.
    wire [7:0] clr1 = (wr_en && sel_rq1) ? ~pwdata[7:0] : 8'h00;  // [R18]
    wire [7:0] clr2 = (wr_en && sel_rq2) ? ~pwdata[7:0] : 8'h00;  // [R18]
    wire [7:0] clrw = (wr_en && sel_wrq) ? ~pwdata[7:0] : 8'h00;  // [R18]
    assign req_first_next = (req_first_reg & ~clr1) |
        {timer_a_ovf, decoder_serial_done, 1'b1, line_hit};       // [R9] [R19]
    assign req_second_next[7]   = (req_second_reg[7] & ~clr2[7]) |
                                  direct_transfer_evt;
    assign req_second_next[6]   = (req_second_reg[6] & ~clr2[6]) |
                                  converter_done;
    // Bit 5 is a plain read/write bit.
    assign req_second_next[5]   = (wr_en && sel_rq2) ? pwdata[5] :
                                  req_second_reg[5];
    assign req_second_next[4:1] = (req_second_reg[4:1] & ~clr2[4:1]) |
        {timer_g_evt, timer_fh_evt, timer_fl_evt, timer_c_evt};
    assign wake_req_next = (wake_req_reg & ~clrw) | wake_hit;     // [R19]

    // Register storage; acceptance never touches the flags.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin                                                     // [R3] [R5]
            wake_edge_reg  <= `RIC_RST_WAKE_EDGE;
            // Only the stored bits are kept; fixed bits live in the mux, except first request bit 5, which is stored.
            ext_edge_reg   <= 5'(`RIC_RST_EXT_EDGE);
            en_first_reg   <= `RIC_RST_EN;
            en_second_reg  <= 7'(`RIC_RST_EN >> 1);
            req_first_reg  <= `RIC_RST_REQ_FIRST;
            req_second_reg <= 7'(`RIC_RST_REQ_SECOND >> 1);
            wake_req_reg   <= `RIC_RST_WAKE_REQ;
        end
        else
        begin
            if (wr_en && sel_wedg)
                wake_edge_reg <= pwdata[7:0];                     // [R20]
            if (wr_en && sel_xedg)
                ext_edge_reg <= pwdata[4:0];                      // [R12] [R13]
            if (wr_en && sel_en1)
                en_first_reg <= pwdata[7:0];                      // [R16]
            if (wr_en && sel_en2)
                en_second_reg <= pwdata[7:1];                     // [R17]
            req_first_reg  <= req_first_next;
            req_second_reg <= req_second_next;
            wake_req_reg   <= wake_req_next;
        end
    end

    // APB answer: one wait state, so prdata and pready come from flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && unmapped;
            if (psel && !penable)
                prdata <= {24'h000000, rd_data};
        end
    end

    // Gated requests: flag and enable both set; serial ports A and B enter any_pend ungated.
    wire        p_line  = |(req_first_reg[4:0] & en_first_reg[4:0]);
    wire        p_wake  = (|wake_req_reg) && en_first_reg[5];     // [R22]
    wire        p_ser   = req_first_reg[6] && en_first_reg[6];
    wire        p_ta    = req_first_reg[7] && en_first_reg[7];
    wire        p_tc    = req_second_reg[1] && en_second_reg[1];
    wire        p_tfl   = req_second_reg[2] && en_second_reg[2];
    wire        p_tfh   = req_second_reg[3] && en_second_reg[3];
    wire        p_tg    = req_second_reg[4] && en_second_reg[4];
    wire        p_conv  = req_second_reg[6] && en_second_reg[6];
    wire        p_dt    = req_second_reg[7] && en_second_reg[7];  // [R17]
    wire [4:0]  line_pe = req_first_reg[4:0] & en_first_reg[4:0]; // [R22]
    wire        any_pend = p_line || p_wake || p_ser || p_ta || p_tc ||
                           p_tfl || p_tfh || p_tg || serial_port_a_req ||
                           serial_port_b_req || p_conv || p_dt;

    // Fixed priority, lowest vector number first; no reserved vector
    // can come out of this chain.
    wire [4:0] line_vec =
        line_pe[0] ? `RIC_VEC_LINE0 :
        line_pe[1] ? `RIC_VEC_LINE0 + 5'h01 :
        line_pe[2] ? `RIC_VEC_LINE0 + 5'h02 :
        line_pe[3] ? `RIC_VEC_LINE0 + 5'h03 : `RIC_VEC_LINE0 + 5'h04;
    wire [4:0] best_vec =
        p_line            ? line_vec :                            // [R10]
        p_wake            ? `RIC_VEC_WAKE :                       // [R10]
        p_ser             ? `RIC_VEC_SERIAL :
        p_ta              ? `RIC_VEC_TMR_A :
        p_tc              ? `RIC_VEC_TMR_C :
        p_tfl             ? `RIC_VEC_TMR_FL :
        p_tfh             ? `RIC_VEC_TMR_FH :
        p_tg              ? `RIC_VEC_TMR_G :
        serial_port_a_req ? `RIC_VEC_SER_A :
        serial_port_b_req ? `RIC_VEC_SER_B :
        p_conv            ? `RIC_VEC_CONV : `RIC_VEC_DIRECT;      // [R8] [R11]

    // Acceptance needs a boundary, a clear mask and one finished
    // instruction since reset, so the stack can be set up first.
    wire take = (state_reg == ric_pkg::RIC_ST_RUN) && !ccr_i_mask &&
                any_pend && cpu_boundary && first_done_reg;       // [R2] [R7] [R9]

    // Exception sequencer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= ric_pkg::RIC_ST_RESET;                   // [R3]
        else
            case (state_reg)
                ric_pkg::RIC_ST_RESET: state_reg <= ric_pkg::RIC_ST_RVEC; // [R1]
                ric_pkg::RIC_ST_RVEC:
                    if (cpu_exc_done)
                        state_reg <= ric_pkg::RIC_ST_RUN;
                ric_pkg::RIC_ST_RUN:
                    if (take)
                        state_reg <= ric_pkg::RIC_ST_EXC;
                ric_pkg::RIC_ST_EXC:
                    if (cpu_exc_done)
                        state_reg <= ric_pkg::RIC_ST_RUN;
                default: state_reg <= ric_pkg::RIC_ST_RESET;
            endcase
    end

    // CPU side outputs; the mask set by hardware wins over a CPU write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_rst_start   <= 1'b0;
            cpu_int_start   <= 1'b0;
            cpu_int_pending <= 1'b0;
            cpu_vector_num  <= `RIC_VEC_RESET;
            cpu_vector_addr <= 16'h0000;
            ccr_i_mask      <= 1'b1;                              // [R5]
            first_done_reg  <= 1'b0;
        end
        else
        begin
            cpu_rst_start   <= (state_reg == ric_pkg::RIC_ST_RESET); // [R1]
            cpu_int_start   <= take;
            cpu_int_pending <= any_pend && !ccr_i_mask;
            if (state_reg == ric_pkg::RIC_ST_RESET)
            begin
                cpu_vector_num  <= `RIC_VEC_RESET;
                cpu_vector_addr <= vec_addr(`RIC_VEC_RESET);      // [R6]
            end
            else if (take)
            begin
                cpu_vector_num  <= best_vec;
                cpu_vector_addr <= vec_addr(best_vec);            // [R10]
            end
            if (take || state_reg == ric_pkg::RIC_ST_RESET)
                ccr_i_mask <= 1'b1;                               // [R21] [R7]
            else if (cpu_ccr_wr)
                ccr_i_mask <= cpu_ccr_i_val;
            if (state_reg == ric_pkg::RIC_ST_RUN && cpu_boundary)
                first_done_reg <= 1'b1;                           // [R7]
        end
    end

    // Edge events handed on to the converter and timers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_trig_evt <= 1'b0;
            timer_f_edge_evt   <= 1'b0;
            timer_c_edge_evt   <= 1'b0;
        end
        else
        begin
            converter_trig_evt <= conv_hit;                       // [R14]
            timer_f_edge_evt   <= tf_hit;                         // [R14]
            timer_c_edge_evt   <= tc_hit;                         // [R15]
        end
    end

    // Checks on the design's own behaviour.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_vector: assert property (cpu_rst_start |->            // [R6]
        cpu_vector_addr == 16'h0000 && ccr_i_mask)
        else $error("reset vector or mask wrong");
    a_reset_start: assert property (                              // [R1]
        state_reg == ric_pkg::RIC_ST_RESET |=> cpu_rst_start)
        else $error("reset processing did not start");
    a_wait_boundary: assert property (cpu_int_start |->           // [R2]
        $past(cpu_boundary) && $past(state_reg) == ric_pkg::RIC_ST_RUN)
        else $error("interrupt taken off a boundary");
    a_mask_blocks: assert property (                              // [R9]
        ccr_i_mask && !cpu_ccr_wr |=> !cpu_int_start)
        else $error("interrupt taken while masked");
    a_take_masks: assert property (cpu_int_start |-> ccr_i_mask)  // [R21]
        else $error("mask not set on acceptance");
    a_first_instr: assert property (cpu_rst_start |=>             // [R7]
        !cpu_int_start [*2])
        else $error("interrupt before first instruction");
    a_prio_pick: assert property (cpu_int_start |->               // [R8]
        cpu_vector_num == $past(best_vec))
        else $error("wrong priority pick");
    a_vec_legal: assert property (cpu_int_start |->               // [R11]
        cpu_vector_num >= `RIC_VEC_LINE0 &&
        cpu_vector_num != `RIC_VEC_RSVD &&
        cpu_vector_num <= `RIC_VEC_DIRECT &&
        cpu_vector_addr == {10'h000, cpu_vector_num, 1'b0})
        else $error("reserved or mismatched vector");
    a_edge_ones: assert property (pready && !pwrite &&            // [R12]
        $past(sel_xedg && psel) |-> prdata[7:5] == 3'h7)
        else $error("edge select top bits not one");
    a_flag_sticky: assert property ($fell(req_first_reg[7]) |->   // [R18] [R19]
        $past(wr_en && sel_rq1 && !pwdata[7]))
        else $error("flag cleared without a zero write");
    a_one_no_set: assert property (wr_en && sel_rq1 && pwdata[6]  // [R18]
        && !req_first_reg[6] && !decoder_serial_done |=>
        !req_first_reg[6])
        else $error("write of one set a flag");
    a_gate_enable: assert property (cpu_int_start &&              // [R22]
        cpu_vector_num == `RIC_VEC_TMR_A |->
        $past(en_first_reg[7] && req_first_reg[7]))
        else $error("disabled source was taken");

    c_take_line: cover property (cpu_int_start &&
        cpu_vector_num == `RIC_VEC_LINE0);
    c_take_wake: cover property (cpu_int_start &&
        cpu_vector_num == `RIC_VEC_WAKE);
    c_set_clear: cover property (wr_en && sel_wrq && |wake_hit);
    c_nested_wait: cover property (any_pend && ccr_i_mask ##1 !ccr_i_mask);

endmodule // ric_top

/* test_reset_and_interrupt_control.sv */
// Self-checking bench for the reset and interrupt controller.
`timescale 1ns/10ps
`include "ric_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end

module test_reset_and_interrupt_control;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [4:1]  ext_line_n;
    logic [7:0]  wakeup_line_n;
    logic converter_trigger_in_n, timer_f_event_in, timer_c_event_in;
    logic decoder_internal_line_n, timer_a_ovf, decoder_serial_done;
    logic timer_c_evt, timer_fl_evt, timer_fh_evt, timer_g_evt;
    logic serial_port_a_req, serial_port_b_req, converter_done;
    logic direct_transfer_evt, cpu_boundary, cpu_exc_done, cpu_ccr_wr;
    logic cpu_ccr_i_val, cpu_rst_start, cpu_int_start, cpu_int_pending;
    logic ccr_i_mask, want_unmask;
    logic converter_trig_evt, timer_f_edge_evt, timer_c_edge_evt;
    logic [4:0]  cpu_vector_num;
    logic [15:0] cpu_vector_addr;
    logic [31:0] rdat;
    logic        err;
    int          bad_count = 0;
    int          cmp_count = 0;
    logic [15:0] idx_t [7] = '{`RIC_IDX_WAKE_EDGE, `RIC_IDX_EXT_EDGE,
        `RIC_IDX_EN_FIRST, `RIC_IDX_EN_SECOND, `RIC_IDX_REQ_FIRST,
        `RIC_IDX_REQ_SECOND, `RIC_IDX_WAKE_REQ};
    logic [7:0]  rst_t [7] = '{8'h00, 8'hE0, 8'h00, 8'h00, 8'h20, 8'h00,
        8'h00};

    ric_top ric_top_inst (.*);
    ric_cpu_model ric_cpu_model_inst (.*);

    // Free-running 10 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [15:0] idx,
                       input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, w};
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: only the watchdog may end this wait.
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err  = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(rdat, {24'h0, e})
    endtask

    // Lets the model unmask, then waits for acceptance of one request.
    task automatic wait_int(input logic [4:0] vec);
        want_unmask <= 1'b1;
        do @(posedge pclk); while (cpu_int_start !== 1'b1);
        want_unmask <= 1'b0;
        `CHK(cpu_vector_num, vec)
        `CHK(cpu_vector_addr, {10'h0, vec, 1'b0})
        `CHK(ccr_i_mask, 1'b1)
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected few hundred cycles.
    initial
    begin
        #2000000;
        bad_count++;
        conclude();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, want_unmask} = '0;
        {timer_a_ovf, decoder_serial_done, timer_c_evt, timer_fl_evt} = '0;
        {timer_fh_evt, timer_g_evt, serial_port_a_req} = '0;
        {serial_port_b_req, converter_done, direct_transfer_evt} = '0;
        {timer_f_event_in, timer_c_event_in} = '1;
        {ext_line_n, wakeup_line_n} = '1;
        {converter_trigger_in_n, decoder_internal_line_n} = '1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(cpu_rst_start, 1'b1)
        `CHK(cpu_vector_addr, 16'h0000)
        `CHK(ccr_i_mask, 1'b1)
        for (int i = 0; i < 7; i++)
            rd_chk(idx_t[i], rst_t[i]);
        apb(1'b1, `RIC_IDX_EXT_EDGE, 8'h1F);
        rd_chk(`RIC_IDX_EXT_EDGE, 8'hFF);
        apb(1'b1, `RIC_IDX_EXT_EDGE, 8'h00);
        rd_chk(`RIC_IDX_EXT_EDGE, 8'hE0);
        apb(1'b1, `RIC_IDX_REQ_FIRST, 8'hFF);
        rd_chk(`RIC_IDX_REQ_FIRST, 8'h20);
        apb(1'b0, 16'h0000, 8'h00);
        `CHK(err, 1'b1)
        // Falling edge on line 2 while masked: flag sets, nothing taken.
        apb(1'b1, `RIC_IDX_EN_FIRST, 8'h04);
        ext_line_n[2] <= 1'b0;
        repeat (3) @(posedge pclk);
        rd_chk(`RIC_IDX_REQ_FIRST, 8'h24);
        `CHK(cpu_int_pending, 1'b0)
        wait_int(5'h06);
        rd_chk(`RIC_IDX_REQ_FIRST, 8'h24);
        apb(1'b1, `RIC_IDX_REQ_FIRST, 8'hFB);
        rd_chk(`RIC_IDX_REQ_FIRST, 8'h20);
        // Timer A and serial raised together; serial outranks timer A.
        apb(1'b1, `RIC_IDX_EN_FIRST, 8'hC0);
        {timer_a_ovf, decoder_serial_done} <= 2'b11;
        @(posedge pclk);
        {timer_a_ovf, decoder_serial_done} <= 2'b00;
        wait_int(5'h0A);
        apb(1'b1, `RIC_IDX_REQ_FIRST, 8'hBF);
        wait_int(5'h0B);
        apb(1'b1, `RIC_IDX_REQ_FIRST, 8'h00);
        apb(1'b1, `RIC_IDX_EN_SECOND, 8'h80);
        direct_transfer_evt <= 1'b1;
        @(posedge pclk);
        direct_transfer_evt <= 1'b0;
        wait_int(5'h14);
        // Rising edge selected on wakeup 0: only the rising edge counts.
        apb(1'b1, `RIC_IDX_WAKE_EDGE, 8'h01);
        wakeup_line_n[0] <= 1'b0;
        repeat (3) @(posedge pclk);
        rd_chk(`RIC_IDX_WAKE_REQ, 8'h00);
        wakeup_line_n[0] <= 1'b1;
        repeat (3) @(posedge pclk);
        rd_chk(`RIC_IDX_WAKE_REQ, 8'h01);
        // Falling edge on the timer C pin shows as a one-cycle event.
        timer_c_event_in <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK(timer_c_edge_evt, 1'b1)
        // Reset in mid-run, held ten cycles, clears vector and flags.
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        `CHK(cpu_vector_addr, 16'h0000)
        presetn <= 1'b1;
        rd_chk(`RIC_IDX_WAKE_REQ, 8'h00);
        conclude();
    end
endmodule // test_reset_and_interrupt_control
